// File: hdl/unif_addr_match.sv
// Purpose: Classify received characters as address bytes and match them
// Assumes: Character strobe from the receiver on the same clock
// Notes:   Outputs are one-cycle pulses, registered
`timescale 1ns/100ps
module unif_addr_match
(
  input  wire logic                 sys_clk_i,     // System clock
  input  wire logic                 reset_i,       // Sync reset, high
  input  wire logic                 nine_bit_en_i, // Nine-bit mode on
  input  wire logic                 rx_valid_i,    // Character strobe
  input  wire unif_pkg::unif_char_s rx_char_i,     // Received character
  input  wire unif_pkg::unif_cmp_s  cmp_i,         // Compare settings
  output logic                      addr_seen_o,   // Address byte pulse
  output logic                      addr_hit_o     // Matching address pulse
);

  logic is_addr;   // Ninth bit marks an address byte
  logic own_hit;   // Masked compare with own address
  logic bc_hit;    // Broadcast compare

  // Parity slot only means address when nine-bit mode is on
  assign is_addr = rx_valid_i & nine_bit_en_i & rx_char_i.ninth;
  // Unmasked bits are don't-care, so an all-ones mask is exact match
  assign own_hit = ((rx_char_i.data ^ cmp_i.slave) & cmp_i.mask)
                   == 8'h00;
  assign bc_hit  = rx_char_i.data == cmp_i.bcast;

  // Register the event pulses
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      addr_seen_o <= 1'b0;
      addr_hit_o  <= 1'b0;
    end
    else
    begin
      addr_seen_o <= is_addr;
      addr_hit_o  <= is_addr & (own_hit | bc_hit);
    end
  end

endmodule

// File: hdl/unif_pkg.sv
// Purpose: Shared constants and types for the nine-bit UART interrupt block
// Assumes: 32-bit APB, one aligned word per register
// Notes:   Register indices are scaled by four to form byte addresses
package unif_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [9:0] IDX_IRQ_CTRL  = 10'h0f6;
  localparam logic [9:0] IDX_IRQ_FLAG  = 10'h0f7;
  localparam logic [9:0] IDX_EXT_CTRL  = 10'h0f8;
  localparam logic [9:0] IDX_SLV_ADDR  = 10'h0f9;
  localparam logic [9:0] IDX_SLV_MASK  = 10'h0fa;
  localparam logic [9:0] IDX_BCAST     = 10'h0fb;

  // Reset values
  localparam logic [7:0] RST_IRQ_CTRL  = 8'h02;
  localparam logic [7:0] RST_IRQ_FLAG  = 8'h00;
  localparam logic [7:0] RST_EXT_CTRL  = 8'h00;
  localparam logic [7:0] RST_SLV_ADDR  = 8'h00;
  localparam logic [7:0] RST_SLV_MASK  = 8'hff;
  localparam logic [7:0] RST_BCAST     = 8'hff;

  // Field positions
  localparam int BIT_IRQ_EN      = 0;  // Interrupt control: enable
  localparam int BIT_IRQ_TYPE    = 1;  // Interrupt control: type select
  localparam int BIT_FLAG        = 0;  // Status: triggered
  localparam int BIT_DEEP_FIFO   = 0;  // Extended control: deep FIFO
  localparam int BIT_BYPASS      = 4;  // Extended control: bypass switch
  localparam int BIT_LVL_LO      = 6;  // Extended control: level mode low
  localparam int BIT_LVL_HI      = 7;  // Extended control: level mode high

  // Receive interrupt levels, indexed by {level mode, trigger code}
  localparam logic [15:0][6:0] RX_LEVEL_TBL = {
    7'h7c, 7'h78, 7'h74, 7'h70,   // Mode 11: 124, 120, 116, 112
    7'h68, 7'h60, 7'h58, 7'h50,   // Mode 10: 104, 96, 88, 80
    7'h40, 7'h30, 7'h20, 7'h10,   // Mode 01: 64, 48, 32, 16
    7'h0e, 7'h08, 7'h04, 7'h01    // Mode 00: 14, 8, 4, 1
  };

  // One received character with its ninth (parity position) bit
  typedef struct packed {
    logic       ninth;   // Address/data indicator in nine-bit mode
    logic [7:0] data;    // Character bits
  } unif_char_s;

  // Address compare settings travelling together
  typedef struct packed {
    logic [7:0] slave;   // Own slave address
    logic [7:0] mask;    // 1 = bit is compared
    logic [7:0] bcast;   // Broadcast address
  } unif_cmp_s;

endpackage

// File: hdl/unif_top.sv
// Purpose: Nine-bit interrupt control, status and extended FIFO control
// Assumes: APB master, receiver and FIFO logic sit outside this block
// Notes:   Zero-wait APB with one registered setup cycle
//
// Function
// - Type 0: interrupt on every address byte
// - Type 1: interrupt only on matching address
// - Control bit 0 gates interrupt; reset 02
// - Status bit 0 shows triggered; reset 00
// - Level modes 00/01 give 1-14, 16-64 bytes
// - Level modes 10/11 give 80-104, 112-124 bytes
// - Extended bit 4 enables channel bypass switch
// - Ninth bit marks address versus data
// - Match own masked address or broadcast
//
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
module unif_top
(
  input  wire logic                 sys_clk_i,       // System clock 10 MHz
  input  wire logic                 reset_i,         // Host bus reset, high
  input  wire logic                 psel_i,          // APB select
  input  wire logic                 penable_i,       // APB enable
  input  wire logic                 pwrite_i,        // APB direction
  input  wire logic [11:0]          paddr_i,         // APB byte address
  input  wire logic [31:0]          pwdata_i,        // APB write data
  output logic      [31:0]          prdata_o,        // APB read data
  output logic                      pready_o,        // APB ready
  output logic                      pslverr_o,       // APB error
  input  wire logic                 nine_bit_en_i,   // Nine-bit mode on
  input  wire logic                 rx_valid_i,      // Character strobe
  input  wire unif_pkg::unif_char_s rx_char_i,       // Received character
  input  wire logic [1:0]           rx_trig_sel_i,   // fifo_control_reg 7:6
  output logic                      irq_o,           // Nine-bit interrupt
  output logic      [6:0]           rx_trig_level_o, // Receive level, bytes
  output logic                      deep_fifo_en_o,  // 128-byte FIFOs
  output logic                      channel_bypass_switch_en_o // Bypass
);

  // Stored register fields; reserved bits are not kept
  logic       irq_en_reg;     // Interrupt enable
  logic       irq_type_reg;   // Interrupt type select
  logic       flag_reg;       // Interrupt triggered
  logic [1:0] lvl_mode_reg;   // FIFO level mode
  logic       bypass_reg;     // Bypass switch enable
  logic       deep_reg;       // Deep FIFO select
  unif_pkg::unif_cmp_s cmp_reg; // Address compare settings

  logic [31:0] rdata_next;    // Read mux
  logic        hit_next;      // Address decodes to a register
  logic        setup;         // APB setup cycle
  logic        wr_acc;        // Write takes effect this edge
  logic [9:0]  idx;           // Word index of the access
  logic        addr_seen;     // Any address byte pulse
  logic        addr_hit;      // Matching address byte pulse
  logic        irq_event;     // Event that sets the flag
  logic        flag_clr;      // Software writes zero to the flag

  assign setup  = psel_i & ~penable_i;
  assign wr_acc = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;
  assign idx    = paddr_i[11:2];

  // Address classification and compare
  unif_addr_match unif_addr_match_inst
  (
    .sys_clk_i     (sys_clk_i),
    .reset_i       (reset_i),
    .nine_bit_en_i (nine_bit_en_i),
    .rx_valid_i    (rx_valid_i),
    .rx_char_i     (rx_char_i),
    .cmp_i         (cmp_reg),
    .addr_seen_o   (addr_seen),
    .addr_hit_o    (addr_hit)
  );

  // Read mux; misaligned or unknown offsets are flagged as errors
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    hit_next   = paddr_i[1:0] == 2'h0;
    case (idx)
      unif_pkg::IDX_IRQ_CTRL:
      begin
        rdata_next[unif_pkg::BIT_IRQ_EN]   = irq_en_reg;
        rdata_next[unif_pkg::BIT_IRQ_TYPE] = irq_type_reg;
      end
      unif_pkg::IDX_IRQ_FLAG:
      begin
        rdata_next[unif_pkg::BIT_FLAG] = flag_reg;
      end
      unif_pkg::IDX_EXT_CTRL:
      begin
        // Reserved bits 5 and 3-1 always read zero
        rdata_next[unif_pkg::BIT_LVL_HI:unif_pkg::BIT_LVL_LO] = lvl_mode_reg;
        rdata_next[unif_pkg::BIT_BYPASS]    = bypass_reg;
        rdata_next[unif_pkg::BIT_DEEP_FIFO] = deep_reg;
      end
      unif_pkg::IDX_SLV_ADDR:
      begin
        rdata_next[7:0] = cmp_reg.slave;
      end
      unif_pkg::IDX_SLV_MASK:
      begin
        rdata_next[7:0] = cmp_reg.mask;
      end
      unif_pkg::IDX_BCAST:
      begin
        rdata_next[7:0] = cmp_reg.bcast;
      end
      default:
      begin
        hit_next = 1'b0;
      end
    endcase
  end

  // APB answer: ready, data and error are prepared in the setup cycle
  // so every bus output comes from a flop with no wait states
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end
    else if (setup)
    begin
      pready_o  <= 1'b1;
      pslverr_o <= ~hit_next;
      prdata_o  <= hit_next ? rdata_next : 32'h0000_0000;
    end
    else
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end
  end

  // Interrupt control register
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      irq_en_reg   <= unif_pkg::RST_IRQ_CTRL[unif_pkg::BIT_IRQ_EN];
      irq_type_reg <= unif_pkg::RST_IRQ_CTRL[unif_pkg::BIT_IRQ_TYPE];
    end
    else if (wr_acc && idx == unif_pkg::IDX_IRQ_CTRL)
    begin
      irq_en_reg   <= pwdata_i[unif_pkg::BIT_IRQ_EN];
      irq_type_reg <= pwdata_i[unif_pkg::BIT_IRQ_TYPE];
    end
  end

  // Extended control register; reserved bits are dropped on write,
  // so a stray one there has no effect
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      lvl_mode_reg <= unif_pkg::RST_EXT_CTRL[unif_pkg::BIT_LVL_HI:
                                             unif_pkg::BIT_LVL_LO];
      bypass_reg   <= unif_pkg::RST_EXT_CTRL[unif_pkg::BIT_BYPASS];
      deep_reg     <= unif_pkg::RST_EXT_CTRL[unif_pkg::BIT_DEEP_FIFO];
    end
    else if (wr_acc && idx == unif_pkg::IDX_EXT_CTRL)
    begin
      lvl_mode_reg <= pwdata_i[unif_pkg::BIT_LVL_HI:unif_pkg::BIT_LVL_LO];
      bypass_reg   <= pwdata_i[unif_pkg::BIT_BYPASS];
      deep_reg     <= pwdata_i[unif_pkg::BIT_DEEP_FIFO];
    end
  end

  // Address compare settings
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      cmp_reg.slave <= unif_pkg::RST_SLV_ADDR;
      cmp_reg.mask  <= unif_pkg::RST_SLV_MASK;
      cmp_reg.bcast <= unif_pkg::RST_BCAST;
    end
    else if (wr_acc)
    begin
      if (idx == unif_pkg::IDX_SLV_ADDR)
      begin
        cmp_reg.slave <= pwdata_i[7:0];
      end
      if (idx == unif_pkg::IDX_SLV_MASK)
      begin
        cmp_reg.mask <= pwdata_i[7:0];
      end
      if (idx == unif_pkg::IDX_BCAST)
      begin
        cmp_reg.bcast <= pwdata_i[7:0];
      end
    end
  end

  // Event selection by type; disabled interrupt records nothing
  assign irq_event = irq_en_reg &
                     (irq_type_reg ? addr_hit
                                   : addr_seen);
  assign flag_clr  = wr_acc && idx == unif_pkg::IDX_IRQ_FLAG &&
                     !pwdata_i[unif_pkg::BIT_FLAG];

  // Triggered flag: sticky, cleared by writing zero, set beats clear
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      flag_reg <= unif_pkg::RST_IRQ_FLAG[unif_pkg::BIT_FLAG];
    end
    else if (irq_event)
    begin
      flag_reg <= 1'b1;
    end
    else if (flag_clr)
    begin
      flag_reg <= 1'b0;
    end
  end

  // Outputs, each from a flop; interrupt lags the flag by one cycle
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      irq_o                      <= 1'b0;
      rx_trig_level_o            <= unif_pkg::RX_LEVEL_TBL[0];
      deep_fifo_en_o             <= 1'b0;
      channel_bypass_switch_en_o <= 1'b0;
    end
    else
    begin
      irq_o           <= flag_reg & irq_en_reg;
      rx_trig_level_o <= unif_pkg::RX_LEVEL_TBL[{lvl_mode_reg,
                                                 rx_trig_sel_i}];
      deep_fifo_en_o             <= deep_reg;
      channel_bypass_switch_en_o <= bypass_reg;
    end
  end

endmodule

// File: tb/unif_node_model.sv
// Purpose: Remote multidrop node sending nine-bit characters
// Assumes: Characters arrive deserialised on the system clock
// Notes:   Idle lines show the inverse of the last character
`timescale 1ns/100ps
module unif_node_model
(
  input  wire logic            clk_i,   // System clock
  output logic                 valid_o, // One-cycle strobe
  output unif_pkg::unif_char_s char_o   // Ninth bit and data
);
  initial
  begin
    valid_o = 1'b0;
    char_o  = '0;
  end
  // Optional idle gap models a slow node
  task automatic send(input logic adr, input logic [7:0] d, input int gap);
    repeat (gap) @(posedge clk_i);
    valid_o <= 1'b1;
    char_o  <= '{ninth: adr, data: d};
    @(posedge clk_i);
    valid_o <= 1'b0;
    char_o  <= ~{adr, d};  // Stale data must never look valid
  endtask
endmodule

// File: tb/unif_sva.sv
// Purpose: Port checks for the nine-bit interrupt block
// Assumes: Zero-wait APB; a mirror follows software writes
// Notes:   Mirror ignores hardware flag sets, so the flag is unused
`timescale 1ns/100ps
module unif_sva
(
  input wire logic        sys_clk_i, reset_i, psel_i, penable_i,
  input wire logic        pwrite_i, pready_o, pslverr_o, irq_o,
  input wire logic        nine_bit_en_i, rx_valid_i, deep_fifo_en_o,
  input wire logic        channel_bypass_switch_en_o,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire unif_pkg::unif_char_s rx_char_i
);
  logic [7:0] sh [8];  // Registers by address bits 4:2
  logic map, wr, clr, hit, ev;
  // Mapped words run from 3d8 to 3ec
  assign map = paddr_i >= 12'h3d8 && paddr_i <= 12'h3ec &&
               paddr_i[1:0] == 2'h0;
  assign wr  = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;
  assign clr = wr && paddr_i == 12'h3dc && !pwdata_i[0];
  assign hit = ((rx_char_i.data ^ sh[1]) & sh[2]) == 8'h00 ||
               rx_char_i.data == sh[3];
  assign ev  = rx_valid_i && nine_bit_en_i && rx_char_i.ninth && sh[6][0];
  // Mirror of software writes, starting from the reset values
  always_ff @(posedge sys_clk_i)
    if (reset_i)
      sh <= '{8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h02, 8'h00};
    else if (wr)
      sh[paddr_i[4:2]] <= pwdata_i[7:0];
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // Address byte, then enable kept through the two-stage path
  sequence s_kept(c);
    c ##1 sh[6][0] [*2];
  endsequence
  sequence s_ext_wr;
    wr && paddr_i == 12'h3e0;
  endsequence
  chk_ready_pulse: assert property (
    psel_i && !penable_i |=> pready_o ##1 !pready_o)
    else $error("ready not one cycle after setup");
  chk_unmapped_err: assert property (
    psel_i && !penable_i && !map |=> pslverr_o)
    else $error("unmapped access not refused");
  chk_any_addr: assert property (
    s_kept(ev && !sh[6][1]) |=> irq_o)
    else $error("address byte gave no interrupt");
  chk_match_only: assert property (
    s_kept(ev && sh[6][1] && hit) |=> irq_o)
    else $error("matching address gave no interrupt");
  chk_gate_off: assert property (
    !sh[6][0] |=> !irq_o)
    else $error("interrupt while disabled");
  chk_flag_held: assert property (
    irq_o && sh[6][0] && !clr && !$past(clr) |=> irq_o)
    else $error("interrupt dropped without clear");
  chk_bypass_cfg: assert property (
    s_ext_wr |-> ##2 channel_bypass_switch_en_o == $past(pwdata_i[4], 2))
    else $error("bypass switch does not follow write");
  chk_deep_cfg: assert property (
    s_ext_wr |-> ##2 deep_fifo_en_o == $past(pwdata_i[0], 2))
    else $error("deep FIFO select does not follow write");
endmodule
bind unif_top unif_sva unif_sva_inst (.sys_clk_i, .reset_i, .psel_i,
  .penable_i, .pwrite_i, .pready_o, .pslverr_o, .irq_o, .nine_bit_en_i,
  .rx_valid_i, .deep_fifo_en_o, .channel_bypass_switch_en_o, .paddr_i,
  .pwdata_i, .rx_char_i);

// File: tb/unif_top_tb.sv
// Purpose: Self-checking bench for the nine-bit interrupt block
// Assumes: Zero-wait APB slave, remote node model on receive side
// Notes:   Reads are queued by the driver and checked by a monitor
`timescale 1ns/100ps
module unif_top_tb;
  logic clk = 1'b0, rst = 1'b1, nine_en = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [1:0] trig = 2'h0;
  logic pready, pslverr, irq, deep, byp, rx_valid;
  logic [6:0] level;
  logic [7:0] s;
  unif_pkg::unif_char_s rx_char;
  logic [32:0] exp_q [$];  // Expected {error, read data}
  int errors = 0, checks = 0;
  int lv [16] = '{1, 4, 8, 14, 16, 32, 48, 64, 80, 88, 96, 104,
                  112, 116, 120, 124};
  always #50 clk = ~clk;
  unif_top unif_top_inst (.sys_clk_i(clk), .reset_i(rst), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .nine_bit_en_i(nine_en), .rx_valid_i(rx_valid),
    .rx_char_i(rx_char), .rx_trig_sel_i(trig), .irq_o(irq),
    .rx_trig_level_o(level), .deep_fifo_en_o(deep),
    .channel_bypass_switch_en_o(byp));
  unif_node_model unif_node_model_inst (.clk_i(clk), .valid_o(rx_valid),
    .char_o(rx_char));
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp_rd(input logic [32:0] act, input logic [32:0] exp);
    checks++;
    if (act !== exp)
    begin
      errors++;
      $display("ERROR %0t: read %h want %h", $time, act, exp);
    end
  endtask
  task automatic cmp_pin(input logic [8:0] act, input logic [8:0] exp);
    checks++;
    if (act !== exp)
    begin
      errors++;
      $display("ERROR %0t: pins %h want %h", $time, act, exp);
    end
  endtask
  // Setup then access; the caller releases or chains the next setup
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    penable <= 1'b0;
  endtask
  task automatic idle;
    psel <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
    idle;
  endtask
  task automatic rd(input logic [11:0] a, input logic e, input logic [7:0] d);
    exp_q.push_back({e, 24'h0, d});
    apb(1'b0, a, 32'h0);
    idle;
  endtask
  // Character in (ninth bit from a), interrupt and flag checked, then flag cleared
  task automatic hit(input logic a, input logic [7:0] d, input logic e);
    unif_node_model_inst.send(a, d, $urandom_range(2));
    repeat (3) @(posedge clk);
    cmp_pin(9'(irq), 9'(e));
    rd(12'h3dc, 1'b0, {7'h0, e});
    wr(12'h3dc, 8'h00);
    @(posedge clk);
    cmp_pin(9'(irq), 9'h000);
  endtask
  // Monitor: each completed read takes the oldest note
  always @(posedge clk)
    if (psel && penable && pready === 1'b1 && !pwrite)
      cmp_rd({pslverr, prdata}, exp_q.pop_front());
  initial
  begin
    repeat (5000) @(posedge clk);
    errors++;
    print_verdict;
  end
  initial
  begin
    void'($urandom(32'hc7b4));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    cmp_pin({irq, byp, level}, 9'h001);
    rd(12'h3d8, 1'b0, 8'h02);
    rd(12'h3dc, 1'b0, 8'h00);
    rd(12'h3e0, 1'b0, 8'h00);
    rd(12'h3e8, 1'b0, 8'hff);
    rd(12'h3ec, 1'b0, 8'hff);
    wr(12'h3f0, 8'h55);
    rd(12'h3f0, 1'b1, 8'h00);
    rd(12'h3d9, 1'b1, 8'h00);
    // Every level mode with every trigger code
    for (int i = 0; i < 16; i++)
    begin
      r = $urandom;
      trig <= i[1:0];
      wr(12'h3e0, {i[3:2], 1'b0, r[4], 3'h0, r[0]});
      @(posedge clk);
      cmp_pin({deep, byp, level}, {r[0], r[4], 7'(lv[i])});
    end
    // Back-to-back write then read
    apb(1'b1, 12'h3e0, 32'h11);
    exp_q.push_back({1'b0, 32'h11});
    apb(1'b0, 12'h3e0, 32'h0);
    idle;
    s = 8'($urandom);
    wr(12'h3e4, s);
    wr(12'h3e8, 8'hf0);
    rd(12'h3e4, 1'b0, s);
    wr(12'h3d8, 8'h01);
    hit(1'b1, ~s, 1'b1);
    hit(1'b0, s, 1'b0);
    nine_en <= 1'b0;
    hit(1'b1, s, 1'b0);
    nine_en <= 1'b1;
    wr(12'h3d8, 8'h03);
    hit(1'b1, s ^ 8'h0f, 1'b1);
    hit(1'b1, s ^ 8'h10, (s ^ 8'h10) == 8'hff);
    hit(1'b1, 8'hff, 1'b1);
    wr(12'h3d8, 8'h02);
    hit(1'b1, s, 1'b0);
    // Gate dropped while the flag stands: output falls, flag is kept
    wr(12'h3d8, 8'h01);
    unif_node_model_inst.send(1'b1, s, 0);
    repeat (3) @(posedge clk);
    wr(12'h3d8, 8'h00);
    @(posedge clk);
    cmp_pin(9'(irq), 9'h000);
    rd(12'h3dc, 1'b0, 8'h01);
    wr(12'h3d8, 8'h01);
    @(posedge clk);
    cmp_pin(9'(irq), 9'h001);
    wr(12'h3dc, 8'h00);
    wr(12'h3dc, 8'h01);
    rd(12'h3dc, 1'b0, 8'h00);
    // Host bus reset in mid-run clears the configuration again
    rst  <= 1'b1;
    trig <= 2'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    cmp_pin({irq, deep, level}, 9'h001);
    rd(12'h3d8, 1'b0, 8'h02);
    rd(12'h3e0, 1'b0, 8'h00);
    print_verdict;
  end
endmodule
